// >>> gpaf_port.sv
// Alternate function routing, output latch modify and input filter top
`timescale 1ns/1ps
module gpaf_port (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic [gpaf_pkg::ADDR_W-1:0]   bus_addr,
    input  wire logic [gpaf_pkg::DATA_W-1:0]   bus_wdata,
    input  wire logic [3:0]                    bus_byte_en,
    input  wire logic                          bus_write,
    input  wire logic                          bus_read,
    output logic      [gpaf_pkg::DATA_W-1:0]   bus_rdata,
    input  wire logic [15:0]                   pin_in,
    output logic      [15:0]                   pin_out_level,
    output logic      [15:0]                   pin_af_level,
    input  wire logic [15:0][15:0]             periph_out,
    output logic      [15:0][15:0]             periph_in,
    output logic      [15:0]                   pin_cond_level
);
    import gpaf_pkg::*;

    // Software state
    logic [31:0]       func_low_reg;
    logic [31:0]       func_high_reg;
    logic [15:0]       latch_reg;
    logic [15:0]       period_reg;
    logic [31:0]       kind_reg;
    logic [31:0]       rdata_reg;

    // Derived per-pin and per-half values
    logic [31:0]       wmask;
    logic [15:0]       wmask16;
    logic [15:0]       latch_next;
    logic [63:0]       func_all;
    logic [PIN_N-1:0]  cond_level;
    logic              low_tick;
    logic              high_tick;
    logic [31:0]       rdata_next;

    logic wr_latch;
    logic wr_func_low;
    logic wr_func_high;
    logic wr_clear;
    logic wr_toggle;
    logic wr_period;
    logic wr_kind;

    // Byte enables widened to a bit mask; a word write enables all four
    assign wmask = {{8{bus_byte_en[3]}}, {8{bus_byte_en[2]}},
                    {8{bus_byte_en[1]}}, {8{bus_byte_en[0]}}};
    assign wmask16 = wmask[15:0];

    assign wr_latch     = bus_write && (bus_addr == OFF_OUT_LATCH);
    assign wr_func_low  = bus_write && (bus_addr == OFF_FUNC_LOW);
    assign wr_func_high = bus_write && (bus_addr == OFF_FUNC_HIGH);
    assign wr_clear     = bus_write && (bus_addr == OFF_OUT_CLEAR);
    assign wr_toggle    = bus_write && (bus_addr == OFF_OUT_TOGGLE);
    assign wr_period    = bus_write && (bus_addr == OFF_FILT_PERIOD);
    assign wr_kind      = bus_write && (bus_addr == OFF_FILT_KIND);

    // Function choice registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            func_low_reg  <= RST_FUNC;
            func_high_reg <= RST_FUNC;
        end else begin
            if (wr_func_low) begin
                // see RQ1
                func_low_reg <= (func_low_reg & ~wmask)
                              | (bus_wdata & wmask); // see RQ4
            end
            if (wr_func_high) begin
                // see RQ3
                func_high_reg <= (func_high_reg & ~wmask)
                               | (bus_wdata & wmask); // see RQ4
            end
        end
    end

    // Output latch: direct write, clear and toggle are lane-masked too.
    // Bits 31:16 of clear and toggle are ignored, so stray ones there do no
    // harm even if software breaks its side of the bargain.
    always_comb begin
        latch_next = latch_reg;
        if (wr_latch) begin
            latch_next = (latch_reg & ~wmask16) | (bus_wdata[15:0] & wmask16);
        end
        if (wr_clear) begin
            latch_next = latch_reg & ~(bus_wdata[15:0] & wmask16); // see RQ5
        end
        if (wr_toggle) begin
            latch_next = latch_reg ^ (bus_wdata[15:0] & wmask16); // see RQ6
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            latch_reg <= RST_LATCH;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // Filter configuration; upper reserved bits are not stored (see RQ7)
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            period_reg <= RST_PERIOD;
            kind_reg   <= RST_KIND; // see RQ11
        end else begin
            if (wr_period) begin
                // see RQ8
                // see RQ9
                period_reg <= (period_reg & ~wmask16)
                            | (bus_wdata[15:0] & wmask16);
            end
            if (wr_kind) begin
                kind_reg <= (kind_reg & ~wmask) | (bus_wdata & wmask);
            end
        end
    end

    // Read path: data stand in the cycle after the strobe only
    always_comb begin
        rdata_next = '0;
        case (bus_addr)
            OFF_IN_STATUS:   rdata_next = {16'h0000, cond_level};
            OFF_OUT_LATCH:   rdata_next = {16'h0000, latch_reg};
            OFF_FUNC_LOW:    rdata_next = func_low_reg;
            OFF_FUNC_HIGH:   rdata_next = func_high_reg;
            OFF_OUT_CLEAR:   rdata_next = '0; // see RQ15
            OFF_OUT_TOGGLE:  rdata_next = '0; // see RQ15
            OFF_FILT_PERIOD: rdata_next = {16'h0000, period_reg};
            OFF_FILT_KIND:   rdata_next = kind_reg;
            default:         rdata_next = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_reg <= '0;
        end else if (bus_read) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign bus_rdata = rdata_reg;

    // One sampling strobe per half-port
    gpaf_sample_tick u_low_tick (
        .clk         (clk),
        .reset_n     (reset_n),
        .divider     (period_reg[LOW_DIV_LSB +: DIV_W]),
        .sample_tick (low_tick)
    );

    gpaf_sample_tick u_high_tick (
        .clk         (clk),
        .reset_n     (reset_n),
        .divider     (period_reg[HIGH_DIV_LSB +: DIV_W]),
        .sample_tick (high_tick)
    );

    assign func_all = {func_high_reg, func_low_reg};

    // Per-pin conditioner and function routing
    for (genvar n = 0; n < PIN_N; n++) begin : g_pin
        gpaf_pin_if link ();
        logic [CODE_W-1:0] code;

        assign link.pin_raw     = pin_in[n];
        assign link.kind        = kind_reg[KIND_W*n +: KIND_W]; // see RQ11
        assign link.sample_tick = (n < HALF_N) ? low_tick : high_tick;
        assign cond_level[n]    = link.cond_level;
        assign code             = func_all[CODE_W*n +: CODE_W];

        gpaf_pin_cond u_cond (
            .clk     (clk),
            .reset_n (reset_n),
            .pin     (link.cond)
        );

        // Selected peripheral drives the pin; only it sees the pin input
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                pin_af_level[n] <= 1'b0;
                periph_in[n]    <= '0;
            end else begin
                pin_af_level[n] <= periph_out[n][code]; // see RQ2
                for (int f = 0; f < PIN_N; f++) begin
                    periph_in[n][f] <= (code == CODE_W'(f))
                                     && cond_level[n]; // see RQ2
                end
            end
        end
    end

    // Registered status copy of the conditioned inputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_cond_level <= '0;
        end else begin
            pin_cond_level <= cond_level;
        end
    end

    assign pin_out_level = latch_reg; // see RQ14
endmodule

// >>> gpaf_pkg.sv
// Constants for the alternate-function, output-modify and input filter block
// Function
// RQ1: Register 0x20 holds 4-bit function codes for pins 0-7, reset zero.
// RQ2: Function code value N routes the pin to alternate function N.
// RQ3: Register 0x24 holds 4-bit function codes for pins 8-15, reset zero.
// RQ4: Writes by byte, half-word or word touch only enabled lanes; reads whole.
// RQ5: Writing 1 at clear register 0x28 bit y clears latch bit y.
// RQ6: Writing 1 at toggle register 0x2C bit y inverts latch bit y.
// RQ7: Software keeps bits 31:16 of clear, toggle, period registers at zero.
// RQ8: Period register 0x30 bits 15:8 set sample divider for pins 8-15.
// RQ9: Period register bits 7:0 set sample divider for pins 0-7.
// RQ10: Divider zero samples every clock; N samples every 2N clocks.
// RQ11: Filter kind register 0x34, two bits per pin, resets to all ones.
// RQ12: Kind 00 synchronises only; kind 11 passes the pin asynchronously.
// RQ13: Kind 01 filters over 3 samples, kind 10 over 6 samples.
// RQ14: Latch register 0x14 bit drives its pin high when 1, low when 0.
// RQ15: Clear and toggle registers read zero with no side effect.
// RQ16: Filtered level changes only after all needed samples agree.
package gpaf_pkg;
    localparam int         ADDR_W          = 8;
    localparam int         DATA_W          = 32;
    localparam int         PIN_N           = 16;
    localparam int         HALF_N          = 8;
    localparam int         CODE_W          = 4;
    localparam int         KIND_W          = 2;
    localparam int         DIV_W           = 8;
    localparam int         CNT_W           = 9;
    localparam int         RUN_W           = 3;
    localparam int         LOW_DIV_LSB     = 0;
    localparam int         HIGH_DIV_LSB    = 8;
    localparam logic [7:0] OFF_IN_STATUS   = 8'h10;
    localparam logic [7:0] OFF_OUT_LATCH   = 8'h14;
    localparam logic [7:0] OFF_FUNC_LOW    = 8'h20;
    localparam logic [7:0] OFF_FUNC_HIGH   = 8'h24;
    localparam logic [7:0] OFF_OUT_CLEAR   = 8'h28;
    localparam logic [7:0] OFF_OUT_TOGGLE  = 8'h2C;
    localparam logic [7:0] OFF_FILT_PERIOD = 8'h30;
    localparam logic [7:0] OFF_FILT_KIND   = 8'h34;
    localparam logic [31:0] RST_FUNC       = 32'h00000000;
    localparam logic [15:0] RST_LATCH      = 16'h0000;
    localparam logic [15:0] RST_PERIOD     = 16'h0000;
    localparam logic [31:0] RST_KIND       = 32'hFFFFFFFF;
    localparam logic [1:0] KIND_SYNC       = 2'h0;
    localparam logic [1:0] KIND_FILT3      = 2'h1;
    localparam logic [1:0] KIND_FILT6      = 2'h2;
    localparam logic [1:0] KIND_ASYNC      = 2'h3;
    localparam logic [2:0] SAMPLES_SHORT   = 3'h3;
    localparam logic [2:0] SAMPLES_LONG    = 3'h6;
endpackage

// >>> gpaf_pin_if.sv
// Per-pin link between the register block and one input conditioner
`timescale 1ns/1ps
interface gpaf_pin_if;
    import gpaf_pkg::*;
    logic              pin_raw;
    logic [KIND_W-1:0] kind;
    logic              sample_tick;
    logic              cond_level;
    modport ctrl (output pin_raw, output kind, output sample_tick,
                  input cond_level);
    modport cond (input pin_raw, input kind, input sample_tick,
                  output cond_level);
endinterface

// >>> gpaf_sample_tick.sv
// Sampling strobe generator for one half-port
`timescale 1ns/1ps
module gpaf_sample_tick (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic [gpaf_pkg::DIV_W-1:0] divider,
    output logic                           sample_tick
);
    import gpaf_pkg::*;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] last_cnt;

    // Period is 2N clocks, so the count runs 0 .. 2N-1
    assign last_cnt = {divider, 1'b0} - {{(CNT_W-1){1'b0}}, 1'b1};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_reg <= '0;
        end else if (divider == '0 || cnt_reg >= last_cnt) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // see RQ10
    assign sample_tick = (divider == '0) || (cnt_reg >= last_cnt);
endmodule

// >>> gpaf_pin_cond.sv
// Input conditioner for one pin: sync, 3/6-sample filter or bypass
`timescale 1ns/1ps
module gpaf_pin_cond (
    input  wire logic clk,
    input  wire logic reset_n,
    gpaf_pin_if.cond  pin
);
    import gpaf_pkg::*;

    logic             meta_reg;
    logic             sync_reg;
    logic             filt_reg;
    logic [RUN_W-1:0] run_reg;
    logic [RUN_W-1:0] need;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= pin.pin_raw;
            sync_reg <= meta_reg;
        end
    end

    assign need = (pin.kind == KIND_FILT6) ? SAMPLES_LONG : SAMPLES_SHORT;

    // Outside the filter kinds the filter tracks the synced level so that a
    // switch into filtering starts from the present pin level
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            filt_reg <= 1'b0;
            run_reg  <= '0;
        end else if (pin.kind != KIND_FILT3 && pin.kind != KIND_FILT6) begin
            filt_reg <= sync_reg;
            run_reg  <= '0;
        end else if (pin.sample_tick) begin
            if (sync_reg == filt_reg) begin
                run_reg <= '0; // see RQ16
            end else if (run_reg + 3'h1 >= need) begin
                filt_reg <= sync_reg; // see RQ13
                run_reg  <= '0;
            end else begin
                run_reg <= run_reg + 3'h1;
            end
        end
    end

    // Bypass is combinational by intent: no clock between pin and cond_level; each user sees it through one register
    always_comb begin
        case (pin.kind)
            KIND_SYNC:  pin.cond_level = sync_reg;     // see RQ12
            KIND_ASYNC: pin.cond_level = pin.pin_raw;  // see RQ12
            default:    pin.cond_level = filt_reg;
        endcase
    end
endmodule

// >>> gpaf_port_sva.sv
// Concurrent checks on the port block's bus, output latch and function routing
`timescale 1ns/1ps
module gpaf_port_sva (
    input wire logic                        clk,
    input wire logic                        reset_n,
    input wire logic [gpaf_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [gpaf_pkg::DATA_W-1:0] bus_wdata,
    input wire logic [3:0]                  bus_byte_en,
    input wire logic                        bus_write,
    input wire logic                        bus_read,
    input wire logic [gpaf_pkg::DATA_W-1:0] bus_rdata,
    input wire logic [15:0]                 pin_in,
    input wire logic [15:0]                 pin_out_level,
    input wire logic [15:0]                 pin_af_level,
    input wire logic [15:0][15:0]           periph_out,
    input wire logic [15:0][15:0]           periph_in,
    input wire logic [15:0]                 pin_cond_level
);
    import gpaf_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_rdata_idle: assert property (
        !bus_read |=> bus_rdata == 32'h0) else $error("stray read data");
    a_strobe_read: assert property (
        bus_read && (bus_addr == 8'h28 || bus_addr == 8'h2C)
        |=> bus_rdata == 32'h0) else $error("strobe register read nonzero");
    a_reserved_zero: assert property (
        bus_read && (bus_addr == 8'h14 || bus_addr == 8'h30)
        |=> bus_rdata[31:16] == 16'h0) else $error("upper half nonzero");
    a_latch_hold: assert property (
        !bus_write |=> $stable(pin_out_level)) else $error("latch moved");
    a_clear_bits: assert property (
        bus_write && bus_addr == 8'h28 && bus_byte_en == 4'hF
        |=> pin_out_level == ($past(pin_out_level) & ~16'($past(bus_wdata))))
        else $error("clear result wrong");
    a_toggle_bits: assert property (
        bus_write && bus_addr == 8'h2C && bus_byte_en == 4'hF
        |=> pin_out_level == ($past(pin_out_level) ^ 16'($past(bus_wdata))))
        else $error("toggle result wrong");
    a_low_lane: assert property (
        bus_write && bus_addr == 8'h2C && bus_byte_en == 4'h1
        |=> ((pin_out_level ^ $past(pin_out_level)) & 16'hFF00) == 16'h0)
        else $error("disabled lane changed");
    a_one_route: assert property (
        $onehot0(periph_in[0]) && $onehot0(periph_in[15]))
        else $error("several functions fed");
endmodule

bind gpaf_port gpaf_port_sva u_sva (.clk(clk), .reset_n(reset_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_byte_en(bus_byte_en),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .pin_in(pin_in), .pin_out_level(pin_out_level),
    .pin_af_level(pin_af_level), .periph_out(periph_out),
    .periph_in(periph_in), .pin_cond_level(pin_cond_level));

// >>> gpaf_far_side.sv
// Pin sources and peripheral outputs that face the port block
`timescale 1ns/1ps
module gpaf_far_side (
    input  wire logic [15:0]       pin_drive,
    input  wire logic [3:0]        hot_fn,
    output logic      [15:0]       pin_in,
    output logic      [15:0][15:0] periph_out
);
    assign pin_in = pin_drive;
    // Only one function per pin is high, so a wrong route reads low
    always_comb begin
        for (int n = 0; n < 16; n++) begin
            periph_out[n] = 16'h0001 << hot_fn;
        end
    end
endmodule

// >>> gpaf_port_bench.sv
// Register, latch, routing and input conditioning tests for the port block
`timescale 1ns/1ps
module gpaf_port_bench;
    import gpaf_pkg::*;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic [ADDR_W-1:0] bus_addr = 8'h00;
    logic [DATA_W-1:0] bus_wdata = 32'h0;
    logic [DATA_W-1:0] bus_rdata;
    logic [3:0]        bus_byte_en = 4'h0;
    logic              bus_write = 1'b0;
    logic              bus_read = 1'b0;
    logic [15:0]       pin_in, pin_out_level, pin_af_level, pin_cond_level;
    logic [15:0]       pin_drive = 16'h0;
    logic [3:0]        hot_fn = 4'h0;
    logic [15:0][15:0] periph_out, periph_in;
    logic [31:0]       rd_val;
    int                failures = 0;
    int                n_checks = 0;
    int                cycles = 0;
    logic [7:0]        r_addr [7] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30,
                                      8'h34, 8'h3C};
    logic [31:0]       r_exp [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                                     32'hFFFFFFFF, 32'h0};

    gpaf_port dut (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_byte_en(bus_byte_en),
        .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
        .pin_in(pin_in), .pin_out_level(pin_out_level),
        .pin_af_level(pin_af_level), .periph_out(periph_out),
        .periph_in(periph_in), .pin_cond_level(pin_cond_level));
    gpaf_far_side far (.pin_drive(pin_drive), .hot_fn(hot_fn),
        .pin_in(pin_in), .periph_out(periph_out));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic conclude();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard: the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        @(posedge clk);
        bus_write   <= 1'b1;
        bus_addr    <= a;
        bus_wdata   <= d;
        bus_byte_en <= be;
        @(posedge clk);
        bus_write   <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus_read <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_read <= 1'b0;
        #1 rd_val = bus_rdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic setp(input logic [15:0] v);
        @(posedge clk);
        pin_drive <= v;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(r_addr[i]);
            chk("reset value", r_exp[i], rd_val);
        end
        wr(8'h24, 32'hFFFFA5FF, 4'h2);
        rd(8'h24);
        chk("lane write", 32'h0000A500, rd_val);
        wr(8'h20, 32'h76543210, 4'hF);
        rd(8'h20);
        chk("function low", 32'h76543210, rd_val);
        wr(8'h24, 32'hFEDCBA98, 4'hF);
        rd(8'h24);
        chk("function high", 32'hFEDCBA98, rd_val);
        // Pin n carries code n, so exactly pin f follows function f
        for (int f = 0; f < 16; f++) begin
            @(posedge clk);
            hot_fn <= 4'(f);
            wait_cyc(2);
            chk("route", 32'h1 << f, {16'h0, pin_af_level});
        end
        wr(8'h14, 32'h0000FFFF, 4'hF);
        wr(8'h28, 32'h000000F0, 4'hF);
        chk("clear", 32'hFF0F, {16'h0, pin_out_level});
        wr(8'h2C, 32'h00000F0F, 4'h1);
        chk("toggle lane", 32'hFF00, {16'h0, pin_out_level});
        wr(8'h2C, 32'h00008001, 4'hF);
        chk("toggle", 32'h7F01, {16'h0, pin_out_level});
        rd(8'h2C);
        chk("toggle read", 32'h0, rd_val);
        rd(8'h28);
        chk("clear read", 32'h0, rd_val);
        chk("latch kept", 32'h7F01, {16'h0, pin_out_level});
        rd(8'h14);
        chk("latch read", 32'h7F01, rd_val);
        wr(8'h30, 32'h00000100, 4'h3);
        rd(8'h30);
        chk("period", 32'h00000100, rd_val);
        setp(16'h0002);
        wait_cyc(2);
        chk("async", 32'h0002, {16'h0, pin_cond_level});
        setp(16'h0000);
        wait_cyc(3);
        wr(8'h34, 32'h00020001, 4'hF);
        setp(16'h0002);
        wait_cyc(2);
        chk("sync early", 32'h0, {16'h0, pin_cond_level});
        wait_cyc(2);
        chk("sync", 32'h0002, {16'h0, pin_cond_level});
        // Two-clock pulse on filtered pins must be swallowed
        setp(16'h0103);
        wait_cyc(1);
        setp(16'h0002);
        wait_cyc(8);
        chk("glitch", 32'h0002, {16'h0, pin_cond_level});
        setp(16'h0103);
        wait_cyc(4);
        chk("filter early", 32'h0002, {16'h0, pin_cond_level});
        wait_cyc(3);
        chk("filter3", 32'h0003, {16'h0, pin_cond_level});
        // Pin 8 samples every second clock, so six samples take twelve
        wait_cyc(5);
        chk("divider slow", 32'h0003, {16'h0, pin_cond_level});
        wait_cyc(15);
        chk("filter6", 32'h0103, {16'h0, pin_cond_level});
        chk("feed pin1", 32'h0002, {16'h0, periph_in[1]});
        chk("feed pin8", 32'h0100, {16'h0, periph_in[8]});
        rd(8'h10);
        chk("input status", 32'h0103, rd_val);
        // Reset in mid-run must bring the latch and filter kinds back
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h14);
        chk("latch reset", 32'h0, rd_val);
        rd(8'h34);
        chk("kind reset", 32'hFFFFFFFF, rd_val);
        conclude();
    end
endmodule
